// ==== hw/scsp_buf2.sv ====
// Purpose: Small ready/valid buffer between read prefetch and serial shifter
// Assumes: Same clock on both sides; flush empties it at once
// Notes:   Depth and width shape the storage
`timescale 1ns/1ps
module scsp_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             reset,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0]    wr_ptr_reg;
    logic [PW-1:0]    rd_ptr_reg;
    logic [PW:0]      cnt_reg;
    logic             push;
    logic             pop;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : next_ptr

    assign in_ready  = (cnt_reg != (PW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || flush) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg    <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= next_ptr(wr_ptr_reg);
            end
            if (pop) begin
                rd_ptr_reg <= next_ptr(rd_ptr_reg);
            end
            cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule : scsp_buf2

// ==== hw/scsp_pkg.sv ====
// Purpose: Shared constants and types of the two-wire configuration target port
// Assumes: System clock of 40 MHz; nine clock outputs; eight configuration bytes
// Notes:   Identity bytes are top-level parameters, not fixed here
package scsp_pkg;
    localparam int           CLK_MHZ        = 40;
    localparam int           T_DRVPD_US     = 300;
    localparam int           T_STAB_MS      = 1;
    localparam int           DRVPD_CYC      = T_DRVPD_US * CLK_MHZ;
    localparam int           STAB_CYC       = T_STAB_MS * 1000 * CLK_MHZ;
    localparam int           F_SCL_MAX_KHZ  = 400;
    localparam int           SCL_HALF_CYC   = (CLK_MHZ * 1000) / (2 * F_SCL_MAX_KHZ);
    localparam int           OE_LAT_MAX_CLK = 3;
    localparam int           NUM_OUT        = 9;
    localparam int           CFG_BYTES      = 8;
    localparam int           SYNC_W         = 15;
    localparam logic [14:0]  SYNC_RST       = 15'h61ff;
    localparam logic [6:0]   REF_IDLE_LAST  = 7'h3f;
    localparam logic [6:0]   ADDR_LOW       = 7'h6b;
    localparam logic [6:0]   ADDR_MID       = 7'h6c;
    localparam logic [6:0]   ADDR_HIGH      = 7'h6d;
    localparam logic [1:0]   SEL_LOW        = 2'h0;
    localparam logic [1:0]   SEL_MID        = 2'h1;
    localparam logic [2:0]   IDX_OE_LO      = 3'h0;
    localparam logic [2:0]   IDX_OE_HI      = 3'h1;
    localparam logic [2:0]   IDX_REV        = 3'h5;
    localparam logic [2:0]   IDX_DEV        = 3'h6;
    localparam logic [2:0]   IDX_COUNT      = 3'h7;
    localparam int           OE8_BIT        = 5;
    localparam logic [2:0]   BIT_LAST       = 3'h7;
    localparam logic [7:0]   READ_PAST_END  = 8'h00;
    localparam logic [7:0]   CFG_RESET [CFG_BYTES] =
        '{8'hff, 8'h6e, 8'hff, 8'hc7, 8'hff, 8'h00, 8'h00, 8'h08};
    localparam logic [7:0]   CFG_WMASK [CFG_BYTES] =
        '{8'hff, 8'h23, 8'hff, 8'h01, 8'h00, 8'h00, 8'h00, 8'h1f};

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RX   = 3'b001,
        ST_ACK  = 3'b010,
        ST_TX   = 3'b011,
        ST_RACK = 3'b100
    } scsp_state_t;

    typedef enum logic [1:0] {
        PH_ADDR  = 2'b00,
        PH_INDEX = 2'b01,
        PH_COUNT = 2'b10,
        PH_DATA  = 2'b11
    } scsp_phase_t;
endpackage : scsp_pkg

// ==== hw/scsp_top.sv ====
// Purpose: Two-wire configuration target port and output gating of a clock fanout buffer
// Assumes: All pins asynchronous to clk_sys; reference clock well below 20 MHz to be seen
// Notes:   Identity bytes are parameters; configuration survives power-down
// Function
// - Write address after start is acknowledged by the device.
// - Index byte follows address, is acknowledged and becomes current index.
// - Count byte follows index in writes and is acknowledged.
// - Data bytes index..index+count-1 are each acknowledged.
// - Block read: address, index, repeated start, read address acknowledged.
// - Device sends read-back count byte first, then configuration bytes in order.
// - Port works up to 400 kHz serial clock; host stays below.
// - Port answers nothing while the reference clock stands still.
// - Output starts or stops within one to three reference clocks of enable pin.
// - Outputs driven within 300 us of power-down release.
// - First output clock within 1 ms of release with running input.
// - Address select latched at first power-good high; picks one of three addresses.
// - Power-down low holds both legs of every output low.
// - Cleared output-enable configuration bit forces that output low on both legs.
// - Writable byte count sets read length; default eight bytes; here it is only sent first, and reads run until host NACK.
`timescale 1ns/1ps
module scsp_top #(
    parameter logic [7:0] ID_REV_VENDOR = 8'h00,
    parameter logic [7:0] ID_DEVICE     = 8'h00,
    parameter int         DRVPD_CYCLES  = scsp_pkg::DRVPD_CYC,
    parameter int         STAB_CYCLES   = scsp_pkg::STAB_CYC,
    parameter int         BUF_DEPTH     = 2
) (
    input  wire logic                         clk_sys,
    input  wire logic                         reset,
    input  wire logic                         scl_in,
    input  wire logic                         sda_in,
    output logic                              sda_out,
    output logic                              sda_oe_n,
    input  wire logic                         ref_clk_in,
    input  wire logic                         power_good_powerdown_n,
    input  wire logic [1:0]                   target_address_select,
    input  wire logic [scsp_pkg::NUM_OUT-1:0] output_enable_n,
    output logic      [scsp_pkg::NUM_OUT-1:0] diff_clock_output_p,
    output logic      [scsp_pkg::NUM_OUT-1:0] diff_clock_output_n
);
    import scsp_pkg::*;

    // ID_REV_VENDOR and ID_DEVICE defaults are arbitrary values
    logic [SYNC_W-1:0]  sync_s1_reg;
    logic [SYNC_W-1:0]  sync_s2_reg;
    logic               scl_s2, sda_s2, ref_s2, pg_s2;
    logic [1:0]         sel_s2;
    logic [NUM_OUT-1:0] oe_n_s2;
    logic               scl_d_reg, sda_d_reg, ref_d_reg;
    logic               scl_rise, scl_fall, start_det, stop_det, ref_rise;
    logic [6:0]         ref_idle_cnt_reg;
    logic               ref_running_reg;
    logic               port_active;
    logic               addr_latched_reg;
    logic [6:0]         target_addr_reg;
    logic [7:0]         cfg_mem [CFG_BYTES];
    scsp_state_t        st_reg;
    scsp_phase_t        ph_reg;
    logic [2:0]         bit_cnt_reg;
    logic [7:0]         rx_sh_reg, rx_byte, tx_sh_reg;
    logic [7:0]         index_reg, remain_reg;
    logic               ack_reg, ack_drv_reg, rd_mode_reg, host_ack_reg, tx_first_reg;
    logic               byte_done, addr_match, rd_accept, wr_en, tx_load;
    logic               pf_active_reg, pf_first_reg;
    logic [7:0]         pf_ptr_reg, pf_data, buf_data;
    logic               buf_in_ready, buf_out_valid, buf_flush;
    logic [NUM_OUT-1:0] cfg_oe, out_en_reg;
    logic               drive_reg;

    function automatic logic [7:0] cfg_rd(input logic [7:0] idx);
        cfg_rd = (idx < 8'(CFG_BYTES)) ? cfg_mem[idx[2:0]] : READ_PAST_END;
    endfunction : cfg_rd

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync_s1_reg <= SYNC_RST;
            sync_s2_reg <= SYNC_RST;
        end else begin
            sync_s1_reg <= {scl_in, sda_in, ref_clk_in, power_good_powerdown_n,
                            target_address_select, output_enable_n};
            sync_s2_reg <= sync_s1_reg;
        end
    end
    assign {scl_s2, sda_s2, ref_s2, pg_s2, sel_s2, oe_n_s2} = sync_s2_reg;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            ref_d_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s2;
            sda_d_reg <= sda_s2;
            ref_d_reg <= ref_s2;
        end
    end
    // 40 MHz sampling leaves ample margin at a 400 kHz serial clock
    assign scl_rise  = scl_s2 & ~scl_d_reg;
    assign scl_fall  = ~scl_s2 & scl_d_reg;
    assign start_det = scl_s2 & scl_d_reg & sda_d_reg & ~sda_s2;
    assign stop_det  = scl_s2 & scl_d_reg & ~sda_d_reg & sda_s2;
    assign ref_rise  = ref_s2 & ~ref_d_reg;

    // Reference activity watchdog
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ref_idle_cnt_reg <= '0;
            ref_running_reg  <= 1'b0;
        end else if (ref_s2 != ref_d_reg) begin
            ref_idle_cnt_reg <= '0;
            ref_running_reg  <= 1'b1;
        end else if (ref_idle_cnt_reg == REF_IDLE_LAST) begin
            ref_running_reg  <= 1'b0;
        end else begin
            ref_idle_cnt_reg <= ref_idle_cnt_reg + 7'h01;
        end
    end
    assign port_active = pg_s2 & ref_running_reg;

    // Address strap caught once, at the first power-good high
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            addr_latched_reg <= 1'b0;
            target_addr_reg  <= ADDR_LOW;
        end else if (pg_s2 && !addr_latched_reg) begin
            addr_latched_reg <= 1'b1;
            target_addr_reg  <= (sel_s2 == SEL_LOW) ? ADDR_LOW :
                                (sel_s2 == SEL_MID) ? ADDR_MID : ADDR_HIGH;
        end
    end

    assign rx_byte    = {rx_sh_reg[6:0], sda_s2};
    assign byte_done  = (st_reg == ST_RX) && scl_rise && (bit_cnt_reg == BIT_LAST);
    assign addr_match = (rx_byte[7:1] == target_addr_reg);
    assign rd_accept  = byte_done && (ph_reg == PH_ADDR) && addr_match && rx_byte[0];
    assign wr_en      = byte_done && (ph_reg == PH_DATA) && (remain_reg != 8'h00);
    assign tx_load    = scl_fall && (((st_reg == ST_ACK) && ack_drv_reg && rd_mode_reg) ||
                                     ((st_reg == ST_RACK) && host_ack_reg));

    // Serial engine
    always_ff @(posedge clk_sys) begin
        if (reset || !port_active) begin
            st_reg       <= ST_IDLE;
            ph_reg       <= PH_ADDR;
            bit_cnt_reg  <= '0;
            rx_sh_reg    <= '0;
            tx_sh_reg    <= '0;
            index_reg    <= '0;
            remain_reg   <= '0;
            ack_reg      <= 1'b0;
            ack_drv_reg  <= 1'b0;
            rd_mode_reg  <= 1'b0;
            host_ack_reg <= 1'b0;
            tx_first_reg <= 1'b0;
            sda_oe_n     <= 1'b1;
        end else if (start_det) begin
            st_reg      <= ST_RX;
            ph_reg      <= PH_ADDR;
            bit_cnt_reg <= '0;
            ack_reg     <= 1'b0;
            sda_oe_n    <= 1'b1;
        end else if (stop_det) begin
            st_reg   <= ST_IDLE;
            sda_oe_n <= 1'b1;
        end else begin
            case (st_reg)
                ST_RX: begin
                    if (scl_rise) begin
                        rx_sh_reg   <= rx_byte;
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                    if (byte_done) begin
                        st_reg      <= ST_ACK;
                        ack_reg     <= 1'b1;
                        ack_drv_reg <= 1'b0;
                        case (ph_reg)
                            PH_ADDR: begin
                                if (!addr_match) begin
                                    st_reg  <= ST_IDLE;
                                    ack_reg <= 1'b0;
                                end
                                rd_mode_reg  <= rx_byte[0];
                                tx_first_reg <= rx_byte[0];
                                ph_reg       <= PH_INDEX;
                            end
                            PH_INDEX: begin
                                index_reg <= rx_byte;
                                ph_reg    <= PH_COUNT;
                            end
                            PH_COUNT: begin
                                remain_reg <= rx_byte;
                                ph_reg     <= PH_DATA;
                            end
                            default: begin
                                if (remain_reg != 8'h00) begin
                                    remain_reg <= remain_reg - 8'h01;
                                    index_reg  <= index_reg + 8'h01;
                                end else begin
                                    st_reg  <= ST_IDLE;
                                    ack_reg <= 1'b0;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall && !ack_drv_reg) begin
                        ack_drv_reg <= 1'b1;
                        sda_oe_n    <= 1'b0;
                    end else if (scl_fall) begin
                        bit_cnt_reg <= '0;
                        if (rd_mode_reg) begin
                            st_reg    <= ST_TX;
                            tx_sh_reg <= buf_data;
                            sda_oe_n  <= buf_data[7];
                        end else begin
                            st_reg   <= ST_RX;
                            sda_oe_n <= 1'b1;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall && (bit_cnt_reg == BIT_LAST)) begin
                        st_reg   <= ST_RACK;
                        sda_oe_n <= 1'b1;
                    end else if (scl_fall) begin
                        tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
                        sda_oe_n    <= tx_sh_reg[6];
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    end
                end
                ST_RACK: begin
                    if (scl_rise) begin
                        host_ack_reg <= ~sda_s2;
                        tx_first_reg <= 1'b0;
                        if (!tx_first_reg) begin
                            index_reg <= index_reg + 8'h01;
                        end
                    end else if (tx_load) begin
                        st_reg      <= ST_TX;
                        bit_cnt_reg <= '0;
                        tx_sh_reg   <= buf_data;
                        sda_oe_n    <= buf_data[7];
                    end else if (scl_fall) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: begin
                    st_reg   <= ST_IDLE;
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        sda_out <= 1'b0;
    end

    // Configuration bytes; identity bytes never take writes
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            for (int i = 0; i < CFG_BYTES; i++) begin
                cfg_mem[i] <= CFG_RESET[i];
            end
            cfg_mem[IDX_REV] <= ID_REV_VENDOR;
            cfg_mem[IDX_DEV] <= ID_DEVICE;
        end else if (wr_en && (index_reg < 8'(CFG_BYTES))) begin
            cfg_mem[index_reg[2:0]] <= (cfg_mem[index_reg[2:0]] & ~CFG_WMASK[index_reg[2:0]]) |
                                       (rx_byte & CFG_WMASK[index_reg[2:0]]);
        end
    end

    // Prefetch runs ahead of the shifter; the buffer stalls it
    assign pf_data   = pf_first_reg ? cfg_mem[IDX_COUNT] : cfg_rd(pf_ptr_reg);
    assign buf_flush = start_det | stop_det | ~port_active;

    always_ff @(posedge clk_sys) begin
        if (reset || buf_flush) begin
            pf_active_reg <= 1'b0;
            pf_first_reg  <= 1'b0;
            pf_ptr_reg    <= '0;
        end else if (rd_accept) begin
            pf_active_reg <= 1'b1;
            pf_first_reg  <= 1'b1;
            pf_ptr_reg    <= index_reg;
        end else if (pf_active_reg && buf_in_ready) begin
            pf_first_reg <= 1'b0;
            if (!pf_first_reg) begin
                pf_ptr_reg <= pf_ptr_reg + 8'h01;
            end
        end
    end

    scsp_buf2 #(
        .WIDTH (8),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_sys   (clk_sys),
        .reset     (reset),
        .flush     (buf_flush),
        .in_valid  (pf_active_reg),
        .in_ready  (buf_in_ready),
        .in_data   (pf_data),
        .out_valid (buf_out_valid),
        .out_ready (tx_load),
        .out_data  (buf_data)
    );

    // Output gating; enables move only on a reference rising edge, or clear when power-down goes low
    assign cfg_oe = {cfg_mem[IDX_OE_HI][OE8_BIT], cfg_mem[IDX_OE_LO]};

    always_ff @(posedge clk_sys) begin
        if (reset || !pg_s2) begin
            drive_reg  <= 1'b0;
            out_en_reg <= '0;
        end else begin
            drive_reg <= 1'b1;
            if (ref_rise) begin
                out_en_reg <= {NUM_OUT{drive_reg}} & cfg_oe & ~oe_n_s2;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset || !pg_s2) begin
            diff_clock_output_p <= '0;
            diff_clock_output_n <= '0;
        end else begin
            diff_clock_output_p <= {NUM_OUT{ref_s2}} & out_en_reg & cfg_oe;
            diff_clock_output_n <= {NUM_OUT{~ref_s2}} & out_en_reg & cfg_oe;
        end
    end

    // Helper counters watched only by the checks below
    int drvpd_cnt_reg;
    int stab_cnt_reg;
    always_ff @(posedge clk_sys) begin
        drvpd_cnt_reg <= (reset || !pg_s2 || drive_reg) ? 0 : drvpd_cnt_reg + 1;
        stab_cnt_reg  <= (reset || !pg_s2 || !ref_running_reg || !(|(cfg_oe & ~oe_n_s2)) ||
                          (|diff_clock_output_p)) ? 0 : stab_cnt_reg + 1;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_addr_ack;
        byte_done && (ph_reg == PH_ADDR) && addr_match && !start_det && !stop_det
            |=> ack_reg ##1 (st_reg == ST_ACK)[*1] ##[1:300] !sda_oe_n;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
    property p_addr_nack;
        byte_done && (ph_reg == PH_ADDR) && !addr_match && !start_det && !stop_det
            |=> (st_reg == ST_IDLE) && sda_oe_n;
    endproperty
    a_addr_nack: assert property (p_addr_nack) else $error("foreign address acked");
    property p_index_load;
        byte_done && (ph_reg == PH_INDEX) && !start_det && !stop_det
            |=> index_reg == $past(rx_byte);
    endproperty
    a_index_load: assert property (p_index_load) else $error("index not loaded");
    property p_count_ack;
        byte_done && (ph_reg == PH_COUNT) && !start_det && !stop_det
            |=> ack_reg && (remain_reg == $past(rx_byte)) && (ph_reg == PH_DATA);
    endproperty
    a_count_ack: assert property (p_count_ack) else $error("count byte mishandled");
    property p_data_step;
        wr_en && !start_det && !stop_det
            |=> ack_reg && (index_reg == $past(index_reg) + 8'h01);
    endproperty
    a_data_step: assert property (p_data_step) else $error("data byte not taken");
    property p_count_first;
        tx_load && tx_first_reg |=> tx_sh_reg == cfg_mem[IDX_COUNT];
    endproperty
    a_count_first: assert property (p_count_first) else $error("count not sent first");
    property p_quiet_no_ref;
        !ref_running_reg |=> sda_oe_n && (st_reg == ST_IDLE);
    endproperty
    a_quiet_no_ref: assert property (p_quiet_no_ref) else $error("port active w/o ref");
    property p_oe_on_edge;
        $changed(out_en_reg) && pg_s2 |-> $past(ref_rise);
    endproperty
    a_oe_on_edge: assert property (p_oe_on_edge) else $error("enable off ref edge");
    property p_pd_low;
        !pg_s2 |=> (diff_clock_output_p == '0) && (diff_clock_output_n == '0);
    endproperty
    a_pd_low: assert property (p_pd_low) else $error("outputs live in power-down");
    property p_cfg_off;
        ((diff_clock_output_p | diff_clock_output_n) & ~$past(cfg_oe)) == '0;
    endproperty
    a_cfg_off: assert property (p_cfg_off) else $error("disabled output toggles");
    property p_drvpd;
        drvpd_cnt_reg < DRVPD_CYCLES;
    endproperty
    a_drvpd: assert property (p_drvpd) else $error("drive enable too late");
    property p_stab;
        stab_cnt_reg < STAB_CYCLES;
    endproperty
    a_stab: assert property (p_stab) else $error("first output clock too late");
    property p_addr_hold;
        addr_latched_reg |=> $stable(target_addr_reg);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address relatched");
endmodule : scsp_top

// ==== test/scsp_host.sv ====
// Purpose: Two-wire host model driving clock and data
// Assumes: Data line pulled up; device only pulls it low
// Notes:   Half period of 100 clocks keeps the bus well below its top rate
`timescale 1ns/1ps
module scsp_host (
    input  wire logic clk_sys,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda
);
    localparam int H = 100;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : hw
    task automatic start();
        sda <= 1'b1;
        hw(H);
        scl <= 1'b1;
        hw(H);
        sda <= 1'b0;
        hw(H);
        scl <= 1'b0;
    endtask : start
    task automatic stop();
        sda <= 1'b0;
        hw(H);
        scl <= 1'b1;
        hw(H);
        sda <= 1'b1;
        hw(H);
    endtask : stop
    task automatic bit_io(input logic b, output logic r);
        sda <= b;
        hw(H);
        scl <= 1'b1;
        hw(H / 2);
        r = sda_line;
        hw(H / 2);
        scl <= 1'b0;
    endtask : bit_io
    // Host answer bit: 0 asks for more, 1 ends a read
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ak, a);
    endtask : xfer
endmodule : scsp_host

// ==== test/scsp_top_tb.sv ====
// Purpose: Self-checking bench of the configuration target port
// Assumes: Reference at 200 ns period, strap low, mid after a second reset
// Notes:   Host model owns the two-wire lines
`timescale 1ns/1ps
module scsp_top_tb;
    import scsp_pkg::*;
    logic       clk_sys = 1'b0, reset = 1'b1, ref_clk_in = 1'b0, ref_run = 1'b1;
    logic       power_good_powerdown_n = 1'b1, scl, sda, sda_out, sda_oe_n;
    logic [1:0] target_address_select = 2'h0, rc = 2'h0;
    logic [8:0] output_enable_n = 9'h000, dp, dn;
    logic [7:0] q;
    logic       a;
    int         err_total = 0, n_checks = 0;
    wire        sda_line = sda & (sda_oe_n | sda_out);
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        rc <= rc + 2'h1;
        if (ref_run && rc == 2'h3) ref_clk_in <= ~ref_clk_in;
    end
    scsp_host host (.clk_sys(clk_sys), .sda_line(sda_line), .scl(scl), .sda(sda));
    scsp_top DUT (.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .ref_clk_in(ref_clk_in),
        .power_good_powerdown_n(power_good_powerdown_n),
        .target_address_select(target_address_select),
        .output_enable_n(output_enable_n), .diff_clock_output_p(dp),
        .diff_clock_output_n(dn));
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1) begin
            err_total++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [7:0] d, input string m);
        host.xfer(d, 1'b1, q, a);
        chk(a === 1'b0, m);
    endtask : wr
    task automatic rd(input logic ak, input logic [7:0] e);
        host.xfer(8'hff, ak, q, a);
        chk(q === e, "read byte");
    endtask : rd
    task automatic t_write();
        int i;
        host.start();
        wr({ADDR_LOW, 1'b0}, "addr ack");
        wr(8'h00, "index ack");
        wr(8'h02, "count ack");
        wr(8'h00, "data0 ack");
        wr(8'h6e, "data1 ack");
        host.stop();
        host.hw(40);
        chk(dp[7:0] === 8'h00 && dn[7:0] === 8'h00, "forced low");
        for (i = 0; i < 400 && dp[8] !== 1'b1; i++) @(posedge clk_sys);
        chk(i < 400, "out8 idle");
        // Three reference clocks are 24 system clocks
        output_enable_n[8] <= 1'b1;
        host.hw(24);
        chk(dp[8] === 1'b0 && dn[8] === 1'b0, "pin off");
        output_enable_n[8] <= 1'b0;
        for (i = 0; i < 24 && dp[8] !== 1'b1; i++) @(posedge clk_sys);
        chk(i < 24, "pin on");
        $display("write test done");
    endtask : t_write
    task automatic t_read();
        host.start();
        wr({ADDR_LOW, 1'b0}, "addr ack");
        wr(8'h00, "index ack");
        host.start();
        wr({ADDR_LOW, 1'b1}, "read addr ack");
        rd(1'b0, 8'h08);
        rd(1'b0, 8'h00);
        rd(1'b1, 8'h6e);
        host.stop();
        $display("read test done");
    endtask : t_read
    task automatic t_refuse(input logic run, input logic [6:0] ad);
        ref_run <= run;
        host.hw(200);
        host.start();
        host.xfer({ad, 1'b0}, 1'b1, q, a);
        chk(a === 1'b1, "no ack");
        host.stop();
        ref_run <= 1'b1;
        $display("refuse test done");
    endtask : t_refuse
    task automatic t_pd();
        int i;
        power_good_powerdown_n <= 1'b0;
        host.hw(20);
        chk(dp === 9'h000 && dn === 9'h000, "power down");
        power_good_powerdown_n <= 1'b1;
        for (i = 0; i < 400 && dp[8] !== 1'b1; i++) @(posedge clk_sys);
        chk(i < 400, "no restart");
        chk(dn[8] === 1'b0, "legs apart");
        $display("power test done");
    endtask : t_pd
    // Strap is caught only at the first power-good after reset
    task automatic t_strap();
        reset                 <= 1'b1;
        target_address_select <= 2'h1;
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        host.hw(20);
        host.start();
        wr({ADDR_MID, 1'b0}, "mid addr ack");
        wr({5'h00, IDX_COUNT}, "index ack");
        wr(8'h01, "count ack");
        wr(8'h03, "count byte ack");
        host.xfer(8'h55, 1'b1, q, a);
        chk(a === 1'b1, "past count");
        host.stop();
        host.start();
        wr({ADDR_MID, 1'b0}, "mid addr ack");
        wr({5'h00, IDX_COUNT}, "index ack");
        host.start();
        wr({ADDR_MID, 1'b1}, "read addr ack");
        rd(1'b0, 8'h03);
        rd(1'b1, 8'h03);
        host.stop();
        $display("strap test done");
    endtask : t_strap
    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        host.hw(20);
        t_write();
        t_read();
        t_refuse(1'b1, ADDR_MID);
        t_refuse(1'b0, ADDR_LOW);
        t_pd();
        t_strap();
        print_verdict();
    end
endmodule : scsp_top_tb
